// [design/eth_mac_status_counters.sv]
// Ethernet MAC receive/general status flags and missed-frame counter
`timescale 1ns/100ps
// ************************************************
// ************************************************
module eth_mac_status_counters (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic rx_frame_start,
	input wire logic rx_frame_end,
	input wire logic rx_crc_bad,
	input wire logic rx_fifo_overflow,
	input wire logic [2:0] rx_fifo_frames,
	input wire logic rx_pause_frame,
	input wire logic rx_ctrl_frame,
	input wire logic tx_start,
	input wire logic tx_frame_end,
	input wire logic tx_sqe_bad,
	input wire logic tx_deferred,
	input wire logic tx_collision,
	input wire logic tx_pause_sent,
	output logic rx_enable,
	output logic tx_enable,
	output logic full_duplex,
	output logic send_pause,
	output logic tx_hold,
	output logic tx_abort,
	output logic rx_discard,
	output logic rx_irq
);
	// ************************************************
	// Helper functions
	// ************************************************
	// Byte-lane mask from write strobes
	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction
	// True for any address this block answers
	function automatic logic mapped(input logic [31:0] a);
		return a == eth_mac_status_pkg::MAC_COMMAND_OFS ||
			a == eth_mac_status_pkg::IRQ_ENABLE_OFS ||
			a == eth_mac_status_pkg::RX_IRQ_STATUS_OFS ||
			a == eth_mac_status_pkg::GENERAL_STATUS_OFS ||
			a == eth_mac_status_pkg::MISSED_COUNT_OFS;
	endfunction

	// ************************************************
	// Register bus slave
	// ************************************************
	logic aw_full_q; // Write address held
	logic w_full_q; // Write data held
	logic [31:0] wr_addr_q;
	logic [31:0] wr_data_q;
	logic [3:0] wr_strb_q;
	logic wr_fire; // Write commits this cycle
	logic rd_fire; // Read address taken this cycle
	logic [31:0] wbits; // Strobe-masked write data
	logic [31:0] rd_word; // Read mux
	logic [31:0] cmd_q; // mac_command_reg
	logic [31:0] ien_q; // irq_enable_reg
	logic [14:1] rsta_q; // rx_irq_status_reg flags
	logic [11:0] gsta_q; // general_status_reg single flags
	logic [3:0] tally_q; // collision_tally
	logic [15:0] mpc_q; // missed_frame_counter
	logic rx_en_dly_q; // Previous receive_enable
	logic tx_en_dly_q; // Previous transmit_enable
	logic rx_irq_summary;

	// Address and data are taken independently, one write at a time
	assign awready = !aw_full_q && !bvalid;
	assign wready = !w_full_q && !bvalid;
	assign wr_fire = aw_full_q && w_full_q && !bvalid;
	assign arready = !rvalid;
	assign rd_fire = arvalid && arready;
	assign wbits = wr_data_q & lane_mask(wr_strb_q);

	// Capture write address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			wr_addr_q <= 32'h00000000;
		end else if (awvalid && awready) begin
			aw_full_q <= 1'b1;
			wr_addr_q <= awaddr;
		end else if (wr_fire) begin
			aw_full_q <= 1'b0;
		end
	end

	// Capture write data and strobes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_q <= 1'b0;
			wr_data_q <= 32'h00000000;
			wr_strb_q <= 4'h0;
		end else if (wvalid && wready) begin
			w_full_q <= 1'b1;
			wr_data_q <= wdata;
			wr_strb_q <= wstrb;
		end else if (wr_fire) begin
			w_full_q <= 1'b0;
		end
	end

	// Write response, held until bready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= eth_mac_status_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= mapped(wr_addr_q) ? eth_mac_status_pkg::RESP_OKAY :
				eth_mac_status_pkg::RESP_DECERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Read mux; unmapped and reserved bits read zero
	always_comb begin
		rd_word = 32'h00000000;
		case (araddr)
			eth_mac_status_pkg::MAC_COMMAND_OFS: rd_word = cmd_q;
			eth_mac_status_pkg::IRQ_ENABLE_OFS: rd_word = ien_q;
			eth_mac_status_pkg::RX_IRQ_STATUS_OFS: begin
				rd_word = {17'h00000, rsta_q, rx_irq_summary};
			end
			eth_mac_status_pkg::GENERAL_STATUS_OFS: begin
				rd_word = {20'h00000, gsta_q};
				rd_word[eth_mac_status_pkg::GS_TALLY_LSB +: 4] = tally_q;
			end
			eth_mac_status_pkg::MISSED_COUNT_OFS: rd_word = {16'h0000, mpc_q};
			default: rd_word = 32'h00000000;
		endcase
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= eth_mac_status_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= mapped(araddr) ? eth_mac_status_pkg::RESP_OKAY :
				eth_mac_status_pkg::RESP_DECERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ************************************************
	// Control registers
	// ************************************************
	logic wr_cmd;
	logic wr_ien;
	logic wr_rsta;
	logic wr_gsta;
	logic wr_mpc;
	assign wr_cmd = wr_fire && wr_addr_q == eth_mac_status_pkg::MAC_COMMAND_OFS;
	assign wr_ien = wr_fire && wr_addr_q == eth_mac_status_pkg::IRQ_ENABLE_OFS;
	assign wr_rsta = wr_fire &&
		wr_addr_q == eth_mac_status_pkg::RX_IRQ_STATUS_OFS;
	assign wr_gsta = wr_fire &&
		wr_addr_q == eth_mac_status_pkg::GENERAL_STATUS_OFS;
	assign wr_mpc = wr_fire && wr_addr_q == eth_mac_status_pkg::MISSED_COUNT_OFS;

	assign rx_enable = cmd_q[eth_mac_status_pkg::CMD_RX_EN_BIT];
	assign tx_enable = cmd_q[eth_mac_status_pkg::CMD_TX_EN_BIT];
	assign full_duplex = cmd_q[eth_mac_status_pkg::CMD_FULL_DUPLEX_BIT];
	assign send_pause = cmd_q[eth_mac_status_pkg::CMD_SEND_PAUSE_BIT];

	// Command register; pause request drops itself once the frame is out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_q <= eth_mac_status_pkg::CMD_RESET;
		end else if (wr_cmd) begin
			cmd_q <= ((cmd_q & ~lane_mask(wr_strb_q)) | wbits) &
				eth_mac_status_pkg::CMD_MASK;
		end else if (tx_pause_sent) begin
			cmd_q[eth_mac_status_pkg::CMD_SEND_PAUSE_BIT] <= 1'b0;
		end
	end

	// Enable register, bit 0 is the master enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ien_q <= 32'h00000000;
		end else if (wr_ien) begin
			ien_q <= ((ien_q & ~lane_mask(wr_strb_q)) | wbits) &
				eth_mac_status_pkg::IRQ_EN_MASK;
		end
	end

	// Delayed enables to catch software turning them off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_en_dly_q <= 1'b0;
			tx_en_dly_q <= 1'b0;
		end else begin
			rx_en_dly_q <= rx_enable;
			tx_en_dly_q <= tx_enable;
		end
	end

	// ************************************************
	// Receive drops and receive status
	// ************************************************
	logic accept_err;
	logic fifo_full;
	logic crc_drop; // Frame ends with counted CRC failure
	logic off_drop; // Frame arrives while reception is off
	logic full_drop; // Frame arrives with four or more frames buffered
	logic [14:1] rsta_set;
	logic [1:0] miss_inc;
	logic [16:0] mpc_sum;
	logic [15:0] mpc_base;
	logic mpc_read;

	assign accept_err = cmd_q[eth_mac_status_pkg::CMD_ACCEPT_ERR_BIT];
	assign fifo_full = rx_fifo_frames >= eth_mac_status_pkg::RX_FIFO_FULL_FRAMES;
	assign crc_drop = rx_frame_end && rx_crc_bad && !accept_err;
	assign off_drop = rx_frame_start && !rx_enable;
	assign full_drop = rx_frame_start && rx_enable && fifo_full;

	// Discard strobe back to the receive engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_discard <= 1'b0;
		end else begin
			rx_discard <= rx_fifo_overflow || crc_drop || off_drop || full_drop;
		end
	end

	// Missed counter: read clears, write loads, events still add
	assign mpc_read = rd_fire && araddr == eth_mac_status_pkg::MISSED_COUNT_OFS;
	assign miss_inc = 2'(rx_fifo_overflow) + 2'(off_drop) + 2'(crc_drop);
	always_comb begin
		mpc_base = mpc_q;
		if (wr_mpc) begin
			mpc_base = wbits[15:0];
		end else if (mpc_read) begin
			mpc_base = 16'h0000;
		end
	end
	assign mpc_sum = {1'b0, mpc_base} + {15'h0000, miss_inc};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mpc_q <= eth_mac_status_pkg::MISSED_RESET;
		end else begin
			mpc_q <= mpc_sum[15:0];
		end
	end

	// Receive flag sources; unsupported positions stay zero
	always_comb begin
		rsta_set = '0;
		rsta_set[eth_mac_status_pkg::RX_OVERFLOW_BIT] = rx_fifo_overflow;
		rsta_set[eth_mac_status_pkg::RX_CRC_BIT] = crc_drop;
		rsta_set[eth_mac_status_pkg::RX_WRAP_BIT] = mpc_sum[16];
	end

	// Write 1 clears, but a same-cycle event keeps the flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsta_q <= '0;
		end else begin
			rsta_q <= (rsta_q & ~(wr_rsta ? wbits[14:1] : 14'h0000)) |
				rsta_set;
		end
	end

	// Summary is pure logic so clearing the flags drops it at once
	assign rx_irq_summary = |(rsta_q & ien_q[14:1]);
	assign rx_irq = rx_irq_summary &&
		ien_q[eth_mac_status_pkg::IRQ_MASTER_EN_BIT];

	// ************************************************
	// General status
	// ************************************************
	logic [11:0] gsta_set;
	logic half_10m;
	assign half_10m = !full_duplex &&
		!cmd_q[eth_mac_status_pkg::CMD_SPEED_100_BIT];

	// Sources of the general flags; none of them reaches rx_irq
	always_comb begin
		gsta_set = 12'h000;
		gsta_set[eth_mac_status_pkg::GS_CTRL_FRAME_BIT] =
			rx_ctrl_frame && full_duplex;
		gsta_set[eth_mac_status_pkg::GS_RX_HALTED_BIT] =
			rx_en_dly_q && !rx_enable;
		gsta_set[eth_mac_status_pkg::GS_RX_FULL_BIT] = fifo_full;
		gsta_set[eth_mac_status_pkg::GS_POSTPONED_BIT] =
			tx_deferred && !full_duplex;
		gsta_set[eth_mac_status_pkg::GS_TX_HOLD_BIT] = rx_pause_frame ||
			(tx_pause_sent && send_pause);
		gsta_set[eth_mac_status_pkg::GS_QUALITY_BIT] = tx_frame_end &&
			tx_sqe_bad && half_10m &&
			cmd_q[eth_mac_status_pkg::CMD_QUALITY_EN_BIT];
		gsta_set[eth_mac_status_pkg::GS_TX_HALTED_BIT] =
			tx_en_dly_q && !tx_enable;
	end

	// Tally field bits are not flags and are never stored here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gsta_q <= 12'h000;
		end else begin
			gsta_q <= ((gsta_q & ~(wr_gsta ? wbits[11:0] : 12'h000)) |
				gsta_set) & 12'hf07;
		end
	end
	assign tx_hold = gsta_q[eth_mac_status_pkg::GS_TX_HOLD_BIT];

	// Collision tally restarts per frame; sixteenth wraps and aborts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tally_q <= 4'h0;
			tx_abort <= 1'b0;
		end else begin
			tx_abort <= tx_collision &&
				tally_q == eth_mac_status_pkg::TALLY_LAST;
			if (tx_start) begin
				tally_q <= 4'h0;
			end else if (tx_collision) begin
				tally_q <= tally_q + 4'h1;
			end
		end
	end

	// ************************************************
	// Assertions
	// ************************************************
	sequence s_write_taken;
		wr_fire;
	endsequence
	// Response stands with a legal code the cycle after the commit
	sequence s_write_answered;
		bvalid && (bresp == eth_mac_status_pkg::RESP_OKAY ||
			bresp == eth_mac_status_pkg::RESP_DECERR);
	endsequence
	a_write_response_order: assert property (@(posedge aclk)
		disable iff (!aresetn) s_write_taken |=> s_write_answered)
		else $error("write response missing after commit");
	a_overflow_flag_set: assert property (@(posedge aclk)
		disable iff (!aresetn) rx_fifo_overflow |=>
		rsta_q[eth_mac_status_pkg::RX_OVERFLOW_BIT] && rx_discard)
		else $error("overflow not flagged or not dropped");
	a_crc_accept_quiet: assert property (@(posedge aclk)
		disable iff (!aresetn) rx_frame_end && rx_crc_bad && accept_err &&
		!rsta_q[eth_mac_status_pkg::RX_CRC_BIT] |=>
		!rsta_q[eth_mac_status_pkg::RX_CRC_BIT])
		else $error("crc flag set in accept mode");
	a_irq_master_gate: assert property (@(posedge aclk)
		disable iff (!aresetn)
		!ien_q[eth_mac_status_pkg::IRQ_MASTER_EN_BIT] |-> !rx_irq)
		else $error("interrupt without master enable");
	a_summary_falls: assert property (@(posedge aclk)
		disable iff (!aresetn) rsta_q == 14'h0000 |-> !rx_irq_summary)
		else $error("summary high with no flags");
	a_tx_halt_flag: assert property (@(posedge aclk)
		disable iff (!aresetn) $fell(tx_enable) |=>
		gsta_q[eth_mac_status_pkg::GS_TX_HALTED_BIT])
		else $error("transmit halt not flagged");
	a_tally_wraps_abort: assert property (@(posedge aclk)
		disable iff (!aresetn) tx_collision && !tx_start &&
		tally_q == 4'hf |=> tally_q == 4'h0 && tx_abort ##1 !tx_abort)
		else $error("sixteenth collision mishandled");
	a_missed_read_clear: assert property (@(posedge aclk)
		disable iff (!aresetn) mpc_read && !wr_mpc && miss_inc == 2'h0 |=>
		mpc_q == 16'h0000)
		else $error("missed counter not cleared by read");
	a_wrap_on_overflow: assert property (@(posedge aclk)
		disable iff (!aresetn) !wr_mpc && !mpc_read && mpc_q == 16'hffff &&
		miss_inc != 2'h0 |=> rsta_q[eth_mac_status_pkg::RX_WRAP_BIT])
		else $error("counter wrap not flagged");
	a_set_beats_clear: assert property (@(posedge aclk)
		disable iff (!aresetn) wr_gsta && rx_pause_frame |=>
		gsta_q[eth_mac_status_pkg::GS_TX_HOLD_BIT])
		else $error("event lost to clear");
	a_defer_half_only: assert property (@(posedge aclk)
		disable iff (!aresetn) full_duplex && !wr_cmd &&
		!gsta_q[eth_mac_status_pkg::GS_POSTPONED_BIT] |=>
		!gsta_q[eth_mac_status_pkg::GS_POSTPONED_BIT])
		else $error("postponed set in full duplex");
endmodule

// [pkg/eth_mac_status_pkg.sv]
// Constants shared by the Ethernet MAC status and counter block
package eth_mac_status_pkg;
	// ************************************************
	// Register byte addresses
	// ************************************************
	localparam logic [31:0] MAC_COMMAND_OFS = 32'hb00030a0;
	localparam logic [31:0] IRQ_ENABLE_OFS = 32'hb00030a8;
	localparam logic [31:0] RX_IRQ_STATUS_OFS = 32'hb00030ac;
	localparam logic [31:0] GENERAL_STATUS_OFS = 32'hb00030b4;
	localparam logic [31:0] MISSED_COUNT_OFS = 32'hb00030b8;
	// ************************************************
	// mac_command_reg fields
	// ************************************************
	localparam int CMD_RX_EN_BIT = 0;
	localparam int CMD_ACCEPT_ERR_BIT = 2;
	localparam int CMD_TX_EN_BIT = 8;
	localparam int CMD_SEND_PAUSE_BIT = 16;
	localparam int CMD_QUALITY_EN_BIT = 17;
	localparam int CMD_FULL_DUPLEX_BIT = 18;
	localparam int CMD_SPEED_100_BIT = 20;
	localparam logic [31:0] CMD_MASK = 32'h00170105;
	// ************************************************
	// rx_irq_status_reg / irq_enable_reg fields
	// ************************************************
	localparam int RX_SUMMARY_BIT = 0;
	localparam int RX_CRC_BIT = 1;
	localparam int RX_OVERFLOW_BIT = 2;
	localparam int RX_WRAP_BIT = 7;
	localparam int IRQ_MASTER_EN_BIT = 0;
	localparam logic [31:0] IRQ_EN_MASK = 32'h00007fff;
	// ************************************************
	// general_status_reg fields
	// ************************************************
	localparam int GS_CTRL_FRAME_BIT = 0;
	localparam int GS_RX_HALTED_BIT = 1;
	localparam int GS_RX_FULL_BIT = 2;
	localparam int GS_TALLY_LSB = 4;
	localparam int GS_POSTPONED_BIT = 8;
	localparam int GS_TX_HOLD_BIT = 9;
	localparam int GS_QUALITY_BIT = 10;
	localparam int GS_TX_HALTED_BIT = 11;
	// ************************************************
	// Reset values and limits
	// ************************************************
	localparam logic [31:0] CMD_RESET = 32'h00000000;
	localparam logic [15:0] MISSED_RESET = 16'h7fff;
	localparam logic [2:0] RX_FIFO_FULL_FRAMES = 3'h4;
	localparam logic [3:0] TALLY_LAST = 4'hf;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// [tb/eth_mac_event_source.sv]
// Model of the MAC engines and PHY that raise events for the status block
`timescale 1ns/100ps
// ************************************************
// Event source
// ************************************************
module eth_mac_event_source (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] ev_sel,
	input wire logic ev_go,
	output logic rx_frame_start,
	output logic rx_frame_end,
	output logic rx_crc_bad,
	output logic rx_fifo_overflow,
	output logic rx_pause_frame,
	output logic rx_ctrl_frame,
	output logic tx_start,
	output logic tx_frame_end,
	output logic tx_sqe_bad,
	output logic tx_deferred,
	output logic tx_collision,
	output logic tx_pause_sent
);
	// One request fires one single-cycle pulse on the selected line
	always_ff @(posedge aclk) begin
		rx_frame_start <= ev_go && ev_sel == 4'h0;
		rx_frame_end <= ev_go && (ev_sel == 4'h1 || ev_sel == 4'h2);
		rx_fifo_overflow <= ev_go && ev_sel == 4'h3;
		rx_pause_frame <= ev_go && ev_sel == 4'h4;
		rx_ctrl_frame <= ev_go && ev_sel == 4'h5;
		tx_start <= ev_go && ev_sel == 4'h6;
		tx_frame_end <= ev_go && (ev_sel == 4'h7 || ev_sel == 4'hb);
		tx_deferred <= ev_go && ev_sel == 4'h8;
		tx_collision <= ev_go && ev_sel == 4'h9;
		tx_pause_sent <= ev_go && ev_sel == 4'ha;
	end
	// Qualifiers only mean something beside their frame end; elsewhere
	// they toggle, so a design that samples them early is caught
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_crc_bad <= 1'h0;
			tx_sqe_bad <= 1'h0;
		end else begin
			if (ev_go && (ev_sel == 4'h1 || ev_sel == 4'h2)) begin
				rx_crc_bad <= ev_sel == 4'h2;
			end else begin
				rx_crc_bad <= !rx_crc_bad;
			end
			if (ev_go && (ev_sel == 4'h7 || ev_sel == 4'hb)) begin
				tx_sqe_bad <= ev_sel == 4'h7;
			end else begin
				tx_sqe_bad <= !tx_sqe_bad;
			end
		end
	end
endmodule

// [tb/eth_mac_status_counters_test.sv]
// Self-checking bench for the MAC status flags and missed-frame counter
`timescale 1ns/100ps
module eth_mac_status_counters_test;
	// ************************************************
	// Signals
	// ************************************************
	localparam logic [31:0] CMD = eth_mac_status_pkg::MAC_COMMAND_OFS;
	localparam logic [31:0] IEN = eth_mac_status_pkg::IRQ_ENABLE_OFS;
	localparam logic [31:0] RXS = eth_mac_status_pkg::RX_IRQ_STATUS_OFS;
	localparam logic [31:0] GS = eth_mac_status_pkg::GENERAL_STATUS_OFS;
	localparam logic [31:0] MC = eth_mac_status_pkg::MISSED_COUNT_OFS;
	logic aclk = 1'h0, aresetn = 1'h0, ev_go = 1'h0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, v;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [3:0] wstrb = 4'hf, ev_sel = 4'h0;
	logic [2:0] rx_fifo_frames = 3'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, last_resp;
	logic [31:0] rdata;
	logic rx_frame_start, rx_frame_end, rx_crc_bad, rx_fifo_overflow;
	logic rx_pause_frame, rx_ctrl_frame, tx_start, tx_frame_end, tx_sqe_bad;
	logic tx_deferred, tx_collision, tx_pause_sent;
	logic rx_enable, tx_enable, full_duplex, send_pause, tx_hold;
	logic tx_abort, rx_discard, rx_irq;
	logic abort_seen = 1'h0;
	logic [7:0] drops = 8'h0, d0;
	int num_errors = 0;
	int n_compared = 0;
	// Clock at 50 ns period
	always #25 aclk = !aclk;
	eth_mac_status_counters dut (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.rx_frame_start, .rx_frame_end, .rx_crc_bad, .rx_fifo_overflow,
		.rx_fifo_frames, .rx_pause_frame, .rx_ctrl_frame, .tx_start,
		.tx_frame_end, .tx_sqe_bad, .tx_deferred, .tx_collision, .tx_pause_sent,
		.rx_enable, .tx_enable, .full_duplex, .send_pause, .tx_hold, .tx_abort,
		.rx_discard, .rx_irq);
	eth_mac_event_source far_side (.aclk, .aresetn, .ev_sel, .ev_go,
		.rx_frame_start, .rx_frame_end, .rx_crc_bad, .rx_fifo_overflow,
		.rx_pause_frame, .rx_ctrl_frame, .tx_start, .tx_frame_end, .tx_sqe_bad,
		.tx_deferred, .tx_collision, .tx_pause_sent);
	// Pulse outputs are caught here since they stand for one cycle only
	always @(posedge aclk) begin
		if (tx_abort === 1'h1) abort_seen <= 1'h1;
		if (rx_discard === 1'h1) drops <= drops + 8'h1;
	end
	// ************************************************
	// Tasks
	// ************************************************
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [31:0] a, d);
		logic ad, wd;
		ad = 1'h0;
		wd = 1'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && awready === 1'h1) begin
				ad = 1'h1;
				awvalid <= 1'h0;
			end
			if (!wd && wready === 1'h1) begin
				wd = 1'h1;
				wvalid <= 1'h0;
			end
		end
		bready <= 1'h1;
		do @(posedge aclk); while (bvalid !== 1'h1);
		last_resp = bresp;
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(posedge aclk); while (rvalid !== 1'h1);
		d = rdata;
		last_resp = rresp;
		rready <= 1'h0;
	endtask
	// Read a register and compare the masked bits
	task automatic rc(input string nm, input logic [31:0] a, m, e);
		logic [31:0] x;
		rd(a, x);
		chk(nm, x & m, e);
	endtask
	// Ask the far side for one event, then let the flag settle
	task automatic ev(input logic [3:0] code);
		@(posedge aclk);
		ev_sel <= code;
		ev_go <= 1'h1;
		@(posedge aclk);
		ev_go <= 1'h0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic tally_and_finish;
		$display("Compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ************************************************
	// Tests
	// ************************************************
	// Watchdog: tests need a few thousand cycles at most
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		rc("missed rst", MC, 32'hffffffff, 32'h7fff);
		rc("missed rdclr", MC, 32'hffff, 32'h0);
		rc("gstat rst", GS, 32'hffffffff, 32'h0);
		rd(32'hb00030fc, v);
		chk("rd decerr", {30'h0, last_resp}, 32'h3);
		wr(32'hb00030fc, 32'h1);
		chk("wr decerr", {30'h0, last_resp}, 32'h3);
		$display("test reset done");
		// Drops, summary and interrupt gating
		wr(CMD, 32'h101);
		chk("wr okay", {30'h0, last_resp}, 32'h0);
		chk("rx enable", {31'h0, rx_enable}, 32'h1);
		chk("tx enable", {31'h0, tx_enable}, 32'h1);
		ev(4'h2);
		rc("crc flag", RXS, 32'h6, 32'h2);
		ev(4'h3);
		rc("ovf flag", RXS, 32'h6, 32'h6);
		rc("missed 2", MC, 32'hffff, 32'h2);
		wr(IEN, 32'h2);
		rc("summary", RXS, 32'h1, 32'h1);
		chk("irq masked", {31'h0, rx_irq}, 32'h0);
		wr(IEN, 32'h3);
		chk("irq on", {31'h0, rx_irq}, 32'h1);
		wr(RXS, 32'h2);
		rc("summary fall", RXS, 32'h7, 32'h4);
		chk("irq fall", {31'h0, rx_irq}, 32'h0);
		wr(IEN, 32'h5);
		rc("ovf enabled", RXS, 32'h7, 32'h5);
		wr(RXS, 32'h4);
		rc("ovf clear", RXS, 32'h7, 32'h0);
		$display("test receive flags done");
		// Accept mode, receive disabled, write-one-clear
		wr(CMD, 32'h105);
		ev(4'h2);
		rc("accept crc", RXS, 32'h2, 32'h0);
		rc("accept cnt", MC, 32'hffff, 32'h0);
		wr(CMD, 32'h100);
		ev(4'h0);
		rc("rx halted", GS, 32'h2, 32'h2);
		rc("off drop cnt", MC, 32'hffff, 32'h1);
		wr(GS, 32'h0);
		rc("w0 keeps", GS, 32'h2, 32'h2);
		chk("no gs irq", {31'h0, rx_irq}, 32'h0);
		wr(GS, 32'h2);
		rc("w1 clears", GS, 32'h2, 32'h0);
		wr(CMD, 32'h0);
		rc("tx halted", GS, 32'h800, 32'h800);
		$display("test halt and clear done");
		// Collision tally and abort
		wr(CMD, 32'h100);
		ev(4'h6);
		repeat (15) ev(4'h9);
		rc("tally 15", GS, 32'hf0, 32'hf0);
		chk("no abort", {31'h0, abort_seen}, 32'h0);
		ev(4'h9);
		rc("tally wrap", GS, 32'hf0, 32'h0);
		chk("abort", {31'h0, abort_seen}, 32'h1);
		// Signal quality only at 10M half duplex
		wr(CMD, 32'h60100);
		ev(4'h7);
		wr(CMD, 32'h120100);
		ev(4'h7);
		rc("sqe skipped", GS, 32'h400, 32'h0);
		wr(CMD, 32'h20100);
		ev(4'h7);
		rc("sqe set", GS, 32'h400, 32'h400);
		$display("test transmit done");
		// Duplex-dependent flags
		wr(GS, 32'hfff);
		wr(CMD, 32'h40100);
		chk("full duplex", {31'h0, full_duplex}, 32'h1);
		ev(4'h8);
		ev(4'h5);
		rc("full dup", GS, 32'h101, 32'h1);
		wr(GS, 32'hfff);
		wr(CMD, 32'h100);
		ev(4'h8);
		ev(4'h5);
		rc("half dup", GS, 32'h101, 32'h100);
		// Pause received, then pause sent
		ev(4'h4);
		rc("pause rx", GS, 32'h200, 32'h200);
		chk("hold out", {31'h0, tx_hold}, 32'h1);
		wr(GS, 32'h200);
		wr(CMD, 32'h10100);
		chk("pause cmd", {31'h0, send_pause}, 32'h1);
		ev(4'ha);
		rc("pause tx", GS, 32'h200, 32'h200);
		chk("pause done", {31'h0, send_pause}, 32'h0);
		$display("test duplex and pause done");
		// Receive FIFO full, then counter load and wrap
		@(posedge aclk);
		rx_fifo_frames <= 3'h4;
		wr(CMD, 32'h101);
		rd(MC, v);
		d0 = drops;
		ev(4'h0);
		rc("fifo full", GS, 32'h4, 32'h4);
		chk("full drop", {24'h0, 8'(drops - d0)}, 32'h1);
		rc("full no cnt", MC, 32'hffff, 32'h0);
		@(posedge aclk);
		rx_fifo_frames <= 3'h0;
		wr(MC, 32'h1234);
		rc("load", MC, 32'hffff, 32'h1234);
		wr(MC, 32'hffff);
		ev(4'h2);
		rc("wrap flag", RXS, 32'h80, 32'h80);
		rc("wrap count", MC, 32'hffff, 32'h0);
		$display("test counter done");
		tally_and_finish();
	end
endmodule
